// *** logic/scan_host.sv ***
/*
 * Board scan controller: makes the test clock by division and walks the
 * port through instruction scans, data scans and mode-select resets.
 * Assumes the port starts in, and is returned to, Run-Test/Idle.
 */
`timescale 1ns/1ps
module scan_host (
    input wire logic clk,
    input wire logic sys_rst,
    scan_link_if.host link,
    input wire logic start,
    input wire scan_pkg::host_op_t op,
    input wire logic [scan_pkg::LEN_W-1:0] len,
    input wire logic [scan_pkg::BSR_W-1:0] tx_data,
    output logic [scan_pkg::BSR_W-1:0] rx_data,
    output logic busy,
    output logic done
);

    localparam logic [2:0] HALF_M1 = 3'(scan_pkg::TCK_HALF_CYC - 1);

    logic [2:0] div_q; // Half-period divider
    logic tck_q, tms_q, tdi_q; // Link outputs
    logic tdo_s1_q, tdo_s2_q; // Serial input synchroniser
    scan_pkg::host_phase_t phase_q;
    scan_pkg::host_op_t op_q;
    logic [7:0] seq_q; // Remaining mode-select preamble
    logic [3:0] cnt_q; // Preamble bits left
    logic [scan_pkg::LEN_W-1:0] idx_q, sidx_q, last_q;
    logic [scan_pkg::BSR_W-1:0] tx_q, rx_q;
    logic samp_q, done_q;

    // Falling edge of the generated clock
    wire div_end = (div_q == HALF_M1);
    wire ev_fall = div_end & tck_q;
    wire is_last = (idx_q == last_q);

    // Divider sets the test clock period, kept within the port limit
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_q <= 3'h0;
            tck_q <= 1'b0;
        end else begin
            div_q <= div_end ? 3'h0 : div_q + 3'h1;
            tck_q <= div_end ? ~tck_q : tck_q;
        end
    end

    // Serial input from the other end passes two flops
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tdo_s1_q <= 1'b1;
            tdo_s2_q <= 1'b1;
        end else begin
            tdo_s1_q <= link.tdo_line;
            tdo_s2_q <= tdo_s1_q;
        end
    end

    // Sequencer: new link bits on each fall, read back one fall later
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase_q <= scan_pkg::H_IDLE;
            op_q <= scan_pkg::OP_RESET;
            tms_q <= 1'b1;
            tdi_q <= 1'b1;
            seq_q <= 8'h00;
            cnt_q <= 4'h0;
            idx_q <= '0;
            sidx_q <= '0;
            last_q <= '0;
            tx_q <= '0;
            rx_q <= '0;
            samp_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (phase_q == scan_pkg::H_IDLE && start) begin
                // Latch the request and its preamble
                op_q <= op;
                tx_q <= tx_data;
                rx_q <= '0;
                idx_q <= '0;
                last_q <= (len == '0) ? '0 : len - 7'h01;
                seq_q <= (op == scan_pkg::OP_SCAN_IR) ? scan_pkg::SEQ_IR
                    : (op == scan_pkg::OP_SCAN_DR) ? scan_pkg::SEQ_DR : scan_pkg::SEQ_RST;
                cnt_q <= (op == scan_pkg::OP_SCAN_IR) ? scan_pkg::SEQ_IR_N
                    : (op == scan_pkg::OP_SCAN_DR) ? scan_pkg::SEQ_DR_N : scan_pkg::SEQ_RST_N;
                phase_q <= scan_pkg::H_PRE;
            end else if (ev_fall) begin
                samp_q <= 1'b0;
                if (samp_q) begin
                    rx_q[sidx_q] <= tdo_s2_q;
                end
                unique case (phase_q)
                    scan_pkg::H_IDLE: tms_q <= 1'b0;
                    scan_pkg::H_PRE: begin
                        tms_q <= seq_q[0];
                        seq_q <= {1'b0, seq_q[7:1]};
                        cnt_q <= cnt_q - 4'h1;
                        if (cnt_q == 4'h1) begin
                            phase_q <= (op_q == scan_pkg::OP_RESET) ? scan_pkg::H_FIN
                                : scan_pkg::H_SHIFT;
                        end
                    end
                    scan_pkg::H_SHIFT: begin
                        tms_q <= is_last;
                        tdi_q <= tx_q[idx_q];
                        samp_q <= 1'b1;
                        sidx_q <= idx_q;
                        idx_q <= idx_q + 7'h01;
                        if (is_last) begin
                            phase_q <= scan_pkg::H_POST;
                        end
                    end
                    scan_pkg::H_POST: begin
                        tms_q <= 1'b1;
                        phase_q <= scan_pkg::H_FIN;
                    end
                    scan_pkg::H_FIN: begin
                        // Only legal codes are sent by the user side
                        tms_q <= 1'b0;
                        done_q <= 1'b1;
                        phase_q <= scan_pkg::H_IDLE;
                    end
                endcase
            end
        end
    end

    assign link.tck = tck_q;
    assign link.tms = tms_q;
    assign link.tdi = tdi_q;
    assign rx_data = rx_q;
    assign busy = (phase_q != scan_pkg::H_IDLE);
    assign done = done_q;

endmodule // scan_host

// *** logic/scan_link_if.sv ***
/*
 * The four-wire scan link between the board controller and the test port.
 * Assumes the unconnected serial output line floats to a pulled-up high.
 */
`timescale 1ns/1ps
interface scan_link_if;
    logic tck; // Test clock from the controller
    logic tms; // Mode select
    logic tdi; // Serial data into the port
    logic tdo; // Serial data out of the port
    logic tdo_oe; // High while the port drives its serial output
    logic tdo_line; // Resolved level of the serial output line

    // Undriven line reads high through the pull-up
    assign tdo_line = tdo_oe ? tdo : 1'b1;

    modport dev (input tck, input tms, input tdi, output tdo, output tdo_oe);
    modport host (output tck, output tms, output tdi, input tdo_line);
endinterface

// *** logic/scan_pkg.sv ***
/*
 * Shared constants and types for the boundary-scan test port and for the
 * board-level scan controller that drives it.
 * Assumes both ends run on a 50 MHz system clock.
 */
package scan_pkg;

    // System clock period in ns
    localparam int CLK_NS = 20;
    // Least half period of the generated test clock, and its cycle count
    localparam int TCK_HALF_NS = 80;
    localparam int TCK_HALF_CYC = (TCK_HALF_NS + CLK_NS - 1) / CLK_NS;

    // Scan register widths
    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int BSR_W = 89;
    localparam int LEN_W = 7;
    // Boundary cell that gates the output bus drivers under EXTEST
    localparam int OE_CELL = 88;

    // Instruction codes
    localparam logic [2:0] INS_EXTEST = 3'h0;
    localparam logic [2:0] INS_IDCODE = 3'h1;
    localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
    localparam logic [2:0] INS_SAMPLE = 3'h4;
    localparam logic [2:0] INS_BYPASS = 3'h7;
    // Pattern loaded into the instruction shifter in Capture-IR
    localparam logic [2:0] IR_CAPTURE = 3'h1;

    // Identification word fields
    localparam logic [2:0] ID_REV = 3'h0;
    localparam logic [4:0] ID_DEPTH = 5'h0b;
    localparam logic [5:0] ID_ARCH = 6'h08;
    localparam logic [5:0] ID_WIDTH = 6'h27;
    localparam logic ID_PRESENT = 1'b1;

    // Mode-select sequences, first bit in bit 0, and their lengths
    localparam logic [7:0] SEQ_IR = 8'h03;
    localparam logic [3:0] SEQ_IR_N = 4'h4;
    localparam logic [7:0] SEQ_DR = 8'h01;
    localparam logic [3:0] SEQ_DR_N = 4'h3;
    localparam logic [7:0] SEQ_RST = 8'h1f;
    localparam logic [3:0] SEQ_RST_N = 4'h5;

    // Test access port controller states
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } tap_state_t;

    // Host operations
    typedef enum logic [1:0] {
        OP_SCAN_IR, OP_SCAN_DR, OP_RESET
    } host_op_t;

    // Host sequencer phases
    typedef enum logic [2:0] {
        H_IDLE, H_PRE, H_SHIFT, H_POST, H_FIN
    } host_phase_t;

endpackage

// *** logic/scan_tap.sv ***
/*
 * Boundary-scan test access port of a pipelined burst memory: controller,
 * instruction register, bypass, identification and boundary registers.
 * Assumes the test clock, mode select and serial input arrive from outside
 * the system clock domain and are far slower than it.
 */
`timescale 1ns/1ps
module scan_tap #(
    parameter logic [10:0] ID_VENDOR = 11'h05a // Arbitrary maker code
) (
    input wire logic clk,
    input wire logic sys_rst,
    scan_link_if.dev link,
    input wire logic [scan_pkg::BSR_W-1:0] pins_in,
    output logic [scan_pkg::BSR_W-1:0] bsr_drive,
    output logic extest_on,
    output logic q_oe,
    output logic [scan_pkg::IR_W-1:0] instr
);

    // Fixed identification word
    localparam logic [31:0] ID_WORD = {scan_pkg::ID_REV, scan_pkg::ID_DEPTH,
        scan_pkg::ID_ARCH, scan_pkg::ID_WIDTH, ID_VENDOR, scan_pkg::ID_PRESENT};

    // Standard controller transition on one sampled mode-select bit
    function automatic scan_pkg::tap_state_t tap_next(
        input scan_pkg::tap_state_t s,
        input logic m
    );
        scan_pkg::tap_state_t n;
        n = s;
        unique case (s)
            scan_pkg::TLR: n = m ? scan_pkg::TLR : scan_pkg::RTI;
            scan_pkg::RTI: n = m ? scan_pkg::SEL_DR : scan_pkg::RTI;
            scan_pkg::SEL_DR: n = m ? scan_pkg::SEL_IR : scan_pkg::CAP_DR;
            scan_pkg::CAP_DR: n = m ? scan_pkg::EX1_DR : scan_pkg::SHF_DR;
            scan_pkg::SHF_DR: n = m ? scan_pkg::EX1_DR : scan_pkg::SHF_DR;
            scan_pkg::EX1_DR: n = m ? scan_pkg::UPD_DR : scan_pkg::PAU_DR;
            scan_pkg::PAU_DR: n = m ? scan_pkg::EX2_DR : scan_pkg::PAU_DR;
            scan_pkg::EX2_DR: n = m ? scan_pkg::UPD_DR : scan_pkg::SHF_DR;
            scan_pkg::UPD_DR: n = m ? scan_pkg::SEL_DR : scan_pkg::RTI;
            scan_pkg::SEL_IR: n = m ? scan_pkg::TLR : scan_pkg::CAP_IR;
            scan_pkg::CAP_IR: n = m ? scan_pkg::EX1_IR : scan_pkg::SHF_IR;
            scan_pkg::SHF_IR: n = m ? scan_pkg::EX1_IR : scan_pkg::SHF_IR;
            scan_pkg::EX1_IR: n = m ? scan_pkg::UPD_IR : scan_pkg::PAU_IR;
            scan_pkg::PAU_IR: n = m ? scan_pkg::EX2_IR : scan_pkg::PAU_IR;
            scan_pkg::EX2_IR: n = m ? scan_pkg::UPD_IR : scan_pkg::SHF_IR;
            scan_pkg::UPD_IR: n = m ? scan_pkg::SEL_DR : scan_pkg::RTI;
        endcase
        return n;
    endfunction

    // Synchroniser stages for the link inputs
    logic tck_s1_q, tck_s2_q, tck_s3_q;
    logic tms_s1_q, tms_s2_q;
    logic tdi_s1_q, tdi_s2_q;
    // Memory pins come from another clock, so they are synchronised too
    logic [scan_pkg::BSR_W-1:0] pins_s1_q, pins_s2_q;

    // Controller state and scan registers
    scan_pkg::tap_state_t state_q;
    logic [scan_pkg::IR_W-1:0] ir_q; // Active instruction
    logic [scan_pkg::IR_W-1:0] irs_q; // Instruction shifter
    logic byp_q; // Bypass flop
    logic [scan_pkg::ID_W-1:0] id_q; // Identification shifter
    logic [scan_pkg::BSR_W-1:0] bsr_q; // Boundary shift stage
    logic [scan_pkg::BSR_W-1:0] upd_q; // Boundary latched parallel stage
    logic tdo_q, tdo_oe_q; // Serial output and its enable
    logic q_oe_q, extest_q; // Output bus enable and drive mode

    // Second stage is the only reader of the first
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tck_s1_q <= 1'b0;
            tck_s2_q <= 1'b0;
            tck_s3_q <= 1'b0;
            tms_s1_q <= 1'b1;
            tms_s2_q <= 1'b1;
            tdi_s1_q <= 1'b1;
            tdi_s2_q <= 1'b1;
            pins_s1_q <= '0;
            pins_s2_q <= '0;
        end else begin
            tck_s1_q <= link.tck;
            tck_s2_q <= tck_s1_q;
            tck_s3_q <= tck_s2_q;
            tms_s1_q <= link.tms;
            tms_s2_q <= tms_s1_q;
            tdi_s1_q <= link.tdi;
            tdi_s2_q <= tdi_s1_q;
            pins_s1_q <= pins_in;
            pins_s2_q <= pins_s1_q;
        end
    end

    // Test clock edges seen in the system clock
    wire tck_rise = tck_s2_q & ~tck_s3_q;
    wire tck_fall = ~tck_s2_q & tck_s3_q;

    // Instruction decode
    wire sel_id = (ir_q == scan_pkg::INS_IDCODE);
    wire sel_bsr = (ir_q == scan_pkg::INS_EXTEST) | (ir_q == scan_pkg::INS_SAMPLE_Z)
        | (ir_q == scan_pkg::INS_SAMPLE);
    wire sel_byp = ~sel_id & ~sel_bsr;

    // Serial output of the selected data register
    wire dr_out = sel_id ? id_q[0] : (sel_bsr ? bsr_q[0] : byp_q);
    wire in_shift = (state_q == scan_pkg::SHF_DR) | (state_q == scan_pkg::SHF_IR);

    // Next output-bus enable and drive mode
    wire extest_d = (ir_q == scan_pkg::INS_EXTEST);
    wire q_oe_d = (ir_q == scan_pkg::INS_SAMPLE_Z) ? 1'b0
        : (extest_d ? upd_q[scan_pkg::OE_CELL] : 1'b1);

    // Controller advances on each test clock rise
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= scan_pkg::TLR;
        end else if (tck_rise) begin
            state_q <= tap_next(state_q, tms_s2_q);
        end
    end

    // Instruction register: capture, shift, update, reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ir_q <= scan_pkg::INS_IDCODE;
            irs_q <= scan_pkg::IR_CAPTURE;
        end else if (tck_rise) begin
            unique case (state_q)
                scan_pkg::TLR: ir_q <= scan_pkg::INS_IDCODE;
                scan_pkg::CAP_IR: irs_q <= scan_pkg::IR_CAPTURE;
                scan_pkg::SHF_IR: irs_q <= {tdi_s2_q, irs_q[2:1]};
                scan_pkg::UPD_IR: ir_q <= irs_q;
                default: ;
            endcase
        end
    end

    // Bypass and identification registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            byp_q <= 1'b0;
            id_q <= ID_WORD;
        end else if (tck_rise && state_q == scan_pkg::CAP_DR) begin
            byp_q <= 1'b0;
            id_q <= ID_WORD;
        end else if (tck_rise && state_q == scan_pkg::SHF_DR) begin
            // One flop between serial input and output
            if (sel_byp) begin
                byp_q <= tdi_s2_q;
            end
            if (sel_id) begin
                id_q <= {tdi_s2_q, id_q[31:1]};
            end
        end
    end

    // Boundary register shift stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bsr_q <= '0;
        end else if (tck_rise && sel_bsr) begin
            if (state_q == scan_pkg::CAP_DR) begin
                bsr_q <= pins_s2_q;
            end else if (state_q == scan_pkg::SHF_DR) begin
                bsr_q <= {tdi_s2_q, bsr_q[scan_pkg::BSR_W-1:1]};
            end
        end
    end

    // Boundary parallel stage, enable cell preset in reset state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            upd_q <= '0;
            upd_q[scan_pkg::OE_CELL] <= 1'b1;
        end else if (tck_rise && state_q == scan_pkg::TLR) begin
            upd_q[scan_pkg::OE_CELL] <= 1'b1;
        end else if (tck_rise && state_q == scan_pkg::UPD_DR && sel_bsr) begin
            upd_q <= bsr_q;
        end
    end

    // Serial output and its enable change only on test clock fall
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (tck_fall) begin
            tdo_q <= (state_q == scan_pkg::SHF_IR) ? irs_q[0] : dr_out;
            tdo_oe_q <= in_shift;
        end
    end

    // Output bus control toward the memory core
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q_oe_q <= 1'b1;
            extest_q <= 1'b0;
        end else begin
            q_oe_q <= q_oe_d;
            extest_q <= extest_d;
        end
    end

    assign link.tdo = tdo_q;
    assign link.tdo_oe = tdo_oe_q;
    assign bsr_drive = upd_q;
    assign extest_on = extest_q;
    assign q_oe = q_oe_q;
    assign instr = ir_q;

endmodule // scan_tap

// *** verification/scan_checker.sv ***
/*
 * Checker on the four scan wires between controller and test port.
 * Assumes clk samples the link and sys_rst is synchronous, active high.
 */
`timescale 1ns/1ps
module scan_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic tdo_line
);
    logic tck_q; // Test clock one cycle back
    logic last_tms_q; // Mode select seen at the latest rise
    logic [2:0] ones_q; // Run of rises with mode select high
    logic [2:0] ones_d; // Next run length
    wire logic rise_w = tck & ~tck_q; // Test clock rise seen

    // Run length saturates at five, cleared by a low mode select
    assign ones_d = !rise_w ? ones_q : (!tms ? 3'h0 : (ones_q == 3'h5 ? 3'h5 : ones_q + 3'h1));

    // Edge and run tracking
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tck_q <= 1'b0;
            last_tms_q <= 1'b1;
            ones_q <= 3'h0;
        end else begin
            tck_q <= tck;
            last_tms_q <= rise_w ? tms : last_tms_q;
            ones_q <= ones_d;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_rst_oe_off: assert property ($fell(sys_rst) |-> !tdo_oe)
        else $error("serial output driven after reset");
    a_tdo_on_fall: assert property ($changed(tdo) |-> !tck && !$past(tck))
        else $error("serial output moved outside a low test clock");
    a_oe_on_fall: assert property ($changed(tdo_oe) |-> !tck && !$past(tck))
        else $error("output enable moved outside a low test clock");
    a_oe_enter_shift: assert property ($rose(tdo_oe) |-> !last_tms_q)
        else $error("output enabled without entering a shift state");
    a_oe_leave_shift: assert property ($fell(tdo_oe) |-> last_tms_q)
        else $error("output released without leaving a shift state");
    a_five_reset: assert property (ones_q == 3'h5 |-> !tdo_oe)
        else $error("serial output driven after five high rises");
    // Two high rises in a row leave no shift state, so the output is off
    a_oe_off_run: assert property (ones_q >= 3'h2 |-> !tdo_oe)
        else $error("serial output driven two rises after leaving shift");
    a_tck_high: assert property ($rose(tck) |-> tck [*4] ##1 !tck)
        else $error("test clock high time wrong");
    a_tck_low: assert property ($fell(tck) |-> !tck [*4])
        else $error("test clock low time too short");
    a_host_change: assert property ($changed(tms) || $changed(tdi) |-> !tck)
        else $error("mode select or data changed while test clock high");
endmodule // scan_checker

// *** verification/tb.sv ***
/*
 * Testbench joining controller and test port over the scan link.
 * Assumes both ends share clk and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module tb;
    localparam logic [10:0] VEND = 11'h2c3; // Arbitrary maker code
    localparam logic [88:0] P1 = 89'h0a5_5aa5_c33c_0ff0_1234_5678; // Pin pattern
    localparam logic [88:0] P2 = 89'h07f_0f0f_1111_2222_3333_4444; // Preload, enable low
    localparam logic [88:0] P3 = 89'h17f_0f0f_1111_2222_3333_4444; // Preload, enable high
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic start = 1'b0;
    scan_pkg::host_op_t op = scan_pkg::OP_RESET;
    logic [6:0] len = 7'h01;
    logic [88:0] tx_data = '0;
    logic [88:0] pins_in = P1;
    logic [88:0] rx_data, bsr_drive;
    logic busy, done, extest_on, q_oe;
    logic [2:0] instr;
    int failures = 0;
    int checks_done = 0;

    scan_link_if lk();
    scan_host i_scan_host (.clk(clk), .sys_rst(sys_rst), .link(lk), .start(start), .op(op),
        .len(len), .tx_data(tx_data), .rx_data(rx_data), .busy(busy), .done(done));
    scan_tap #(.ID_VENDOR(VEND)) i_scan_tap (.clk(clk), .sys_rst(sys_rst), .link(lk),
        .pins_in(pins_in), .bsr_drive(bsr_drive), .extest_on(extest_on), .q_oe(q_oe),
        .instr(instr));
    scan_checker i_scan_checker (.clk(clk), .sys_rst(sys_rst), .tck(lk.tck), .tms(lk.tms),
        .tdi(lk.tdi), .tdo(lk.tdo), .tdo_oe(lk.tdo_oe), .tdo_line(lk.tdo_line));

    // System clock, 20 ns
    always #10 clk = ~clk;

    // Compare and count
    task automatic chk(input string nm, input logic [88:0] e, input logic [88:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One controller operation, waited for under a bound
    task automatic run(input scan_pkg::host_op_t o, input logic [6:0] n, input logic [88:0] d);
        int k;
        @(negedge clk);
        op = o;
        len = n;
        tx_data = d;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        k = 0;
        while (busy !== 1'b0 && k < 2000) begin
            @(negedge clk);
            k++;
        end
        if (k >= 2000) begin
            failures++;
            $display("[ERR] busy expected 0 seen %b", busy);
        end
        // Done pulse stands in the cycle in which busy drops
        chk("done", 1'b1, done);
        // The port performs Update at the test clock rise after done, seen late
        repeat (12) @(negedge clk);
    endtask

    // Load an instruction and check capture pattern and result
    task automatic load_ir(input logic [2:0] c);
        run(scan_pkg::OP_SCAN_IR, 7'h03, {86'h0, c});
        chk("ir_capture", 89'h1, {87'h0, rx_data[1:0]});
        chk("instr", c, instr);
    endtask

    // Values right after reset
    task automatic t_reset;
        chk("instr", scan_pkg::INS_IDCODE, instr);
        chk("tdo_oe", 1'b0, lk.tdo_oe);
        chk("enable_cell", 1'b1, bsr_drive[88]);
        chk("q_oe", 1'b1, q_oe);
        $display("test reset done");
    endtask

    // Identification word shifted out whole
    task automatic t_idcode;
        run(scan_pkg::OP_SCAN_DR, 7'h20, '0);
        chk("idcode", {scan_pkg::ID_REV, scan_pkg::ID_DEPTH, scan_pkg::ID_ARCH,
            scan_pkg::ID_WIDTH, VEND, 1'b1}, rx_data);
        $display("test idcode done");
    endtask

    // One-stage path, cleared on capture
    task automatic t_bypass;
        load_ir(scan_pkg::INS_BYPASS);
        run(scan_pkg::OP_SCAN_DR, 7'h04, 89'hb);
        chk("bypass_out", 89'h6, rx_data);
        $display("test bypass done");
    endtask

    // Snapshot out while preload goes in
    task automatic t_sample;
        load_ir(scan_pkg::INS_SAMPLE);
        run(scan_pkg::OP_SCAN_DR, 7'h59, P2);
        chk("snapshot", P1, rx_data);
        chk("preload", P2, bsr_drive);
        chk("q_oe", 1'b1, q_oe);
        $display("test sample done");
    endtask

    // Latched enable cell gates the bus under EXTEST
    task automatic t_extest;
        load_ir(scan_pkg::INS_EXTEST);
        chk("extest_on", 1'b1, extest_on);
        chk("q_oe_low", 1'b0, q_oe);
        pins_in = ~P1;
        run(scan_pkg::OP_SCAN_DR, 7'h59, P3);
        chk("capture", ~P1, rx_data);
        chk("drive", P3, bsr_drive);
        chk("q_oe_high", 1'b1, q_oe);
        $display("test extest done");
    endtask

    // Bus held off under sample with high impedance
    task automatic t_samplez;
        load_ir(scan_pkg::INS_SAMPLE_Z);
        chk("q_oe", 1'b0, q_oe);
        run(scan_pkg::OP_SCAN_DR, 7'h59, P2);
        chk("capture", ~P1, rx_data);
        chk("q_oe_still", 1'b0, q_oe);
        $display("test samplez done");
    endtask

    // Five high rises bring back identification and the enable preset
    task automatic t_tlr;
        run(scan_pkg::OP_RESET, 7'h05, '0);
        chk("instr", scan_pkg::INS_IDCODE, instr);
        chk("enable_cell", 1'b1, bsr_drive[88]);
        chk("q_oe", 1'b1, q_oe);
        chk("extest_on", 1'b0, extest_on);
        $display("test tlr done");
    endtask

    // Print counts and verdict, then stop
    task wrap_up;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        #400000;
        failures++;
        wrap_up();
    end

    // Main sequence
    initial begin
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        repeat (20) @(negedge clk);
        t_reset();
        t_idcode();
        t_bypass();
        t_sample();
        t_extest();
        t_samplez();
        t_tlr();
        t_idcode();
        wrap_up();
    end
endmodule // tb
